// [rtl/rdp_key_lock.sv]
// rdp_key_lock: one staged protect bit committed by a key word
// assumes wr_mode and wr_lock are one-cycle strobes of full-word writes
`timescale 1ns/1ps
`default_nettype none
module rdp_key_lock #(
  parameter logic [31:0] KEY = 32'h00000000,
  parameter logic RST_VAL = 1'h1
) (
  input wire logic aclk,
  input wire logic prot_rst,
  rdp_lock_if.lock lk
);
  logic staged_q;
  logic committed_q;

  // ---------------------------------------------------------------------------
  // staging and commit
  // ---------------------------------------------------------------------------
  wire key_hit = lk.wr_lock && (lk.wdata == KEY);

  always_ff @(posedge aclk) begin
    if (prot_rst) begin
      staged_q <= RST_VAL;
      committed_q <= RST_VAL; // R9
    end else begin
      if (lk.wr_mode) begin
        staged_q <= lk.wdata[rdp_pkg::PROTECT_BIT];
      end
      if (key_hit) begin
        committed_q <= staged_q; // R5 R8 R10
      end
    end
  end

  assign lk.committed = committed_q;
endmodule
`default_nettype wire

// [rtl/rdp_lock_if.sv]
// rdp_lock_if: strobes and data from the bus logic to one keyed protect bit
// assumes one driver on the control side, one keyed bit on the lock side
`timescale 1ns/1ps
`default_nettype none
interface rdp_lock_if;
  logic wr_mode;
  logic wr_lock;
  logic [31:0] wdata;
  logic committed;

  modport ctl (output wr_mode, output wr_lock, output wdata, input committed);
  modport lock (input wr_mode, input wr_lock, input wdata, output committed);
endinterface
`default_nettype wire

// [rtl/rdp_pkg.sv]
// rdp_pkg: register map, key words, reset values and bus codes of the protect lock block
// assumes a 32-bit AXI4-Lite register bus and a single 50 MHz system clock
//
// How it works
// (R1) flash variant: protect registers reset only by power-on reset, not system reset
// (R2) mask variant: protect registers reset by every reset
// (R3) software uses only full 32-bit accesses to protect registers
// (R4) both lock registers are write-only; reads return an undefined value
// (R5) writing ROM key to ROM lock commits the staged ROM protect enable bit
// (R6) while ROM protected, protect registers answer only to code fetched from internal ROM
// (R7) debug mode bit 0 is debug disable, reset 1; bits 31..1 read 0
// (R8) writing debug key to debug lock commits the staged debug disable bit
// (R9) ROM protect enable resets to 1; committing 0 releases ROM protection
// (R10) a lock write of any other value leaves the committed bit unchanged
package rdp_pkg;

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_DEBUG_MODE = 32'hffffe510;
  localparam logic [31:0] ADDR_DEBUG_LOCK = 32'hffffe514;
  localparam logic [31:0] ADDR_ROM_MODE = 32'hffffe518;
  localparam logic [31:0] ADDR_ROM_LOCK = 32'hffffe51c;

  // ---------------------------------------------------------------------------
  // fields, keys and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned PROTECT_BIT = 0;
  localparam logic [31:0] ROM_KEY = 32'h0000003d;
  localparam logic [31:0] DEBUG_KEY = 32'h000000c5;
  localparam logic ROM_ENABLE_RST = 1'h1;
  localparam logic DEBUG_DISABLE_RST = 1'h1;
  localparam logic [31:0] LOCK_READ_VALUE = 32'h00000000;
  localparam logic [3:0] STRB_FULL = 4'hf;

  // ---------------------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_DEBUG_MODE = 3'b001,
    SEL_DEBUG_LOCK = 3'b010,
    SEL_ROM_MODE = 3'b011,
    SEL_ROM_LOCK = 3'b100
  } rdp_sel_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HAVE_AW = 2'b01,
    WR_HAVE_W = 2'b10,
    WR_BOTH = 2'b11
  } rdp_wr_state_t;

  typedef enum logic [1:0] {
    WB_IDLE = 2'b00,
    WB_RESP = 2'b01
  } rdp_wb_state_t;

endpackage

// [rtl/rdp_reset_sel.sv]
// rdp_reset_sel: picks the reset that sets the protect bits
// assumes por_n and aresetn are synchronous, active low
`timescale 1ns/1ps
`default_nettype none
module rdp_reset_sel #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  output logic prot_rst
);
  // ---------------------------------------------------------------------------
  // reset choice
  // ---------------------------------------------------------------------------
  wire flash_rst = ~por_n; // R1
  wire mask_rst = ~por_n | ~aresetn; // R2

  assign prot_rst = FLASH_VARIANT ? flash_rst : mask_rst;
endmodule
`default_nettype wire

// [rtl/rdp_top.sv]
// rdp_top: keyed ROM and debug protect registers behind an AXI4-Lite slave
// assumes the bus master keeps AXI4-Lite handshakes and rom_fetch marks
// accesses issued by code fetched from internal ROM
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rdp_top #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic rom_fetch,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rom_protect_enable,
  output logic debug_disable
);

  // ---------------------------------------------------------------------------
  // decode and access check helpers
  // ---------------------------------------------------------------------------
  function automatic rdp_pkg::rdp_sel_t decode(input logic [31:0] addr);
    rdp_pkg::rdp_sel_t sel;
    sel = rdp_pkg::SEL_NONE;
    case (addr)
      rdp_pkg::ADDR_DEBUG_MODE: sel = rdp_pkg::SEL_DEBUG_MODE;
      rdp_pkg::ADDR_DEBUG_LOCK: sel = rdp_pkg::SEL_DEBUG_LOCK;
      rdp_pkg::ADDR_ROM_MODE: sel = rdp_pkg::SEL_ROM_MODE;
      rdp_pkg::ADDR_ROM_LOCK: sel = rdp_pkg::SEL_ROM_LOCK;
      default: sel = rdp_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // protected registers answer only to code running from internal ROM
  function automatic logic allowed(input logic locked, input logic from_rom);
    return ~locked | from_rom;
  endfunction

  function automatic logic [1:0] answer(input rdp_pkg::rdp_sel_t sel, input logic ok,
                                        input logic full);
    logic [1:0] r;
    r = rdp_pkg::RESP_OKAY;
    if (sel == rdp_pkg::SEL_NONE) begin
      r = rdp_pkg::RESP_DECERR;
    end else if (!ok || !full) begin
      r = rdp_pkg::RESP_SLVERR;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // protect reset and keyed bits
  // ---------------------------------------------------------------------------
  logic prot_rst;
  rdp_lock_if rom_lk ();
  rdp_lock_if dbg_lk ();

  rdp_reset_sel #(
    .FLASH_VARIANT(FLASH_VARIANT)
  ) u_rst (
    .aclk(aclk),
    .aresetn(aresetn),
    .por_n(por_n),
    .prot_rst(prot_rst)
  );

  rdp_key_lock #(
    .KEY(rdp_pkg::ROM_KEY),
    .RST_VAL(rdp_pkg::ROM_ENABLE_RST)
  ) u_rom (
    .aclk(aclk),
    .prot_rst(prot_rst),
    .lk(rom_lk.lock)
  );

  rdp_key_lock #(
    .KEY(rdp_pkg::DEBUG_KEY),
    .RST_VAL(rdp_pkg::DEBUG_DISABLE_RST)
  ) u_dbg (
    .aclk(aclk),
    .prot_rst(prot_rst),
    .lk(dbg_lk.lock)
  );

  wire rom_locked = rom_lk.committed;

  // ---------------------------------------------------------------------------
  // write channel state
  // ---------------------------------------------------------------------------
  rdp_pkg::rdp_wr_state_t wr_q;
  rdp_pkg::rdp_wr_state_t wr_d;
  rdp_pkg::rdp_wb_state_t wb_q;
  logic [31:0] awaddr_q;
  logic aw_from_rom_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire aw_hs = s_axi_awvalid && awready_q;
  wire w_hs = s_axi_wvalid && wready_q;
  wire b_hs = bvalid_q && s_axi_bready;
  wire wr_fire = (wr_q == rdp_pkg::WR_BOTH) && (wb_q == rdp_pkg::WB_IDLE);

  wire rdp_pkg::rdp_sel_t wsel = decode(awaddr_q);
  wire w_full = (wstrb_q == rdp_pkg::STRB_FULL); // R3
  wire w_ok = allowed(rom_locked, aw_from_rom_q); // R6
  wire [1:0] w_resp = answer(wsel, w_ok, w_full);
  wire w_commit = wr_fire && (w_resp == rdp_pkg::RESP_OKAY);

  // ---------------------------------------------------------------------------
  // write strobes toward the keyed bits
  // ---------------------------------------------------------------------------
  assign rom_lk.wr_mode = w_commit && (wsel == rdp_pkg::SEL_ROM_MODE);
  assign rom_lk.wr_lock = w_commit && (wsel == rdp_pkg::SEL_ROM_LOCK); // R5
  assign rom_lk.wdata = wdata_q;
  assign dbg_lk.wr_mode = w_commit && (wsel == rdp_pkg::SEL_DEBUG_MODE);
  assign dbg_lk.wr_lock = w_commit && (wsel == rdp_pkg::SEL_DEBUG_LOCK); // R8
  assign dbg_lk.wdata = wdata_q;

  // ---------------------------------------------------------------------------
  // write address and data collection
  // ---------------------------------------------------------------------------
  always_comb begin
    wr_d = wr_q;
    case (wr_q)
      rdp_pkg::WR_IDLE: begin
        if (aw_hs && w_hs) begin
          wr_d = rdp_pkg::WR_BOTH;
        end else if (aw_hs) begin
          wr_d = rdp_pkg::WR_HAVE_AW;
        end else if (w_hs) begin
          wr_d = rdp_pkg::WR_HAVE_W;
        end
      end
      rdp_pkg::WR_HAVE_AW: begin
        if (w_hs) begin
          wr_d = rdp_pkg::WR_BOTH;
        end
      end
      rdp_pkg::WR_HAVE_W: begin
        if (aw_hs) begin
          wr_d = rdp_pkg::WR_BOTH;
        end
      end
      rdp_pkg::WR_BOTH: begin
        if (wr_fire) begin
          wr_d = rdp_pkg::WR_IDLE;
        end
      end
      default: wr_d = rdp_pkg::WR_IDLE;
    endcase
  end

  wire awready_d = ((wr_d == rdp_pkg::WR_IDLE) || (wr_d == rdp_pkg::WR_HAVE_W)) &&
                   !(wr_fire || (wb_q == rdp_pkg::WB_RESP && !b_hs));
  wire wready_d = ((wr_d == rdp_pkg::WR_IDLE) || (wr_d == rdp_pkg::WR_HAVE_AW)) &&
                  !(wr_fire || (wb_q == rdp_pkg::WB_RESP && !b_hs));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= rdp_pkg::WR_IDLE;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 32'h00000000;
      aw_from_rom_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
        aw_from_rom_q <= rom_fetch;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // write response
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_q <= rdp_pkg::WB_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= rdp_pkg::RESP_OKAY;
    end else begin
      case (wb_q)
        rdp_pkg::WB_IDLE: begin
          if (wr_fire) begin
            wb_q <= rdp_pkg::WB_RESP;
            bvalid_q <= 1'b1;
            bresp_q <= w_resp;
          end
        end
        rdp_pkg::WB_RESP: begin
          if (b_hs) begin
            wb_q <= rdp_pkg::WB_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default: begin
          wb_q <= rdp_pkg::WB_IDLE;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire ar_hs = s_axi_arvalid && arready_q;
  wire r_hs = rvalid_q && s_axi_rready;
  wire rdp_pkg::rdp_sel_t rsel = decode(s_axi_araddr);
  wire r_ok = allowed(rom_locked, rom_fetch); // R6
  wire [1:0] r_resp = answer(rsel, r_ok, 1'b1);

  logic [31:0] r_word;
  always_comb begin
    r_word = 32'h00000000;
    case (rsel)
      rdp_pkg::SEL_DEBUG_MODE: r_word[rdp_pkg::PROTECT_BIT] = dbg_lk.committed; // R7
      rdp_pkg::SEL_ROM_MODE: r_word[rdp_pkg::PROTECT_BIT] = rom_lk.committed;
      rdp_pkg::SEL_DEBUG_LOCK: r_word = rdp_pkg::LOCK_READ_VALUE; // R4
      rdp_pkg::SEL_ROM_LOCK: r_word = rdp_pkg::LOCK_READ_VALUE; // R4
      default: r_word = 32'h00000000;
    endcase
  end

  wire [31:0] r_out = (r_resp == rdp_pkg::RESP_OKAY) ? r_word : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= rdp_pkg::RESP_OKAY;
    end else begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= r_out;
        rresp_q <= r_resp;
      end else if (r_hs) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // protect state outputs
  // ---------------------------------------------------------------------------
  logic rom_enable_q;
  logic debug_disable_q;

  always_ff @(posedge aclk) begin
    if (prot_rst) begin
      rom_enable_q <= rdp_pkg::ROM_ENABLE_RST; // R9
      debug_disable_q <= rdp_pkg::DEBUG_DISABLE_RST; // R7
    end else begin
      rom_enable_q <= rom_lk.committed;
      debug_disable_q <= dbg_lk.committed;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rom_protect_enable = rom_enable_q;
  assign debug_disable = debug_disable_q;

endmodule
`default_nettype wire

// [tb/rdp_cpu_model.sv]
// rdp_cpu_model: cpu side bus master issuing single-word accesses
// assumes an AXI4-Lite slave on aclk; slow delays the response ready
`timescale 1ns/1ps
`default_nettype none
module rdp_cpu_model (
  input wire logic aclk,
  output logic rom_fetch,
  output logic [31:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic slow;
  initial begin
    slow = 1'b0;
    {rom_fetch, s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ----------
  // bus cycles
  // ----------
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic f, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    rom_fetch <= f;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    if (slow) begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic f, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    rom_fetch <= f;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    if (slow) begin
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/rdp_top_asserts.sv]
// rdp_top_asserts: port-level checks of the protect lock block
// assumes binding to every rdp_top instance, single clock aclk
`timescale 1ns/1ps
`default_nettype none
module rdp_top_asserts #(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic rom_fetch,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rom_protect_enable,
  input wire logic debug_disable
);
  // ----------
  // helpers
  // ----------
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire mapped = (s_axi_araddr[31:4] == rdp_pkg::ADDR_DEBUG_MODE[31:4]) &&
                (s_axi_araddr[1:0] == 2'h0);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);
  // ----------
  // checks
  // ----------
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read answer");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:1] == 31'h0)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (ar_hs && !mapped |=> s_axi_rvalid
    && s_axi_rresp == rdp_pkg::RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_DENIED: assert property (ar_hs && mapped && rom_protect_enable
    && !s_axi_bvalid && !rom_fetch
    |=> s_axi_rvalid && s_axi_rresp == rdp_pkg::RESP_SLVERR)
    else $error("protected read from outside rom answered");
  AST_ROM_COMMIT: assert property ($changed(rom_protect_enable)
    && $past(aresetn) && $past(por_n)
    |-> $past(s_axi_bvalid) && $past(s_axi_bresp) == rdp_pkg::RESP_OKAY)
    else $error("rom protect changed without write");
  AST_DBG_COMMIT: assert property ($changed(debug_disable)
    && $past(aresetn) && $past(por_n)
    |-> $past(s_axi_bvalid) && $past(s_axi_bresp) == rdp_pkg::RESP_OKAY)
    else $error("debug disable changed without write");
  AST_POR_SET: assert property (disable iff (!aresetn) !por_n
    |=> rom_protect_enable && debug_disable)
    else $error("power-on reset did not set protect bits");
  AST_FLASH_KEEP: assert property (disable iff (!por_n) FLASH_VARIANT && !aresetn
    && !$past(aresetn) |=> $stable(rom_protect_enable) && $stable(debug_disable))
    else $error("system reset touched protect bits");
  AST_MASK_CLEAR: assert property (disable iff (!por_n) !FLASH_VARIANT && !aresetn
    |=> rom_protect_enable && debug_disable)
    else $error("system reset did not set protect bits");
  COV_DENY: cover property (s_axi_rvalid && s_axi_rresp == rdp_pkg::RESP_SLVERR);
  COV_ROM_OFF: cover property ($fell(rom_protect_enable));
  COV_DBG_OFF: cover property ($fell(debug_disable));
endmodule
bind rdp_top rdp_top_asserts #(.FLASH_VARIANT(FLASH_VARIANT)) u_asserts (
  .aclk, .aresetn, .por_n, .rom_fetch, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .rom_protect_enable, .debug_disable
);
`default_nettype wire

// [tb/rom_debug_protect_lock_regs_test.sv]
// rom_debug_protect_lock_regs_test: register-level tests of flash and mask variants
// assumes both variants share one bus; only the flash one answers it
`timescale 1ns/1ps
`default_nettype none
module rom_debug_protect_lock_regs_test;
  localparam logic [31:0] AD_DM = rdp_pkg::ADDR_DEBUG_MODE;
  localparam logic [31:0] AD_DL = rdp_pkg::ADDR_DEBUG_LOCK;
  localparam logic [31:0] AD_RM = rdp_pkg::ADDR_ROM_MODE;
  localparam logic [31:0] AD_RL = rdp_pkg::ADDR_ROM_LOCK;
  localparam logic [1:0] OK = rdp_pkg::RESP_OKAY;
  localparam logic [1:0] SE = rdp_pkg::RESP_SLVERR;
  localparam logic [1:0] DE = rdp_pkg::RESP_DECERR;
  logic aclk, aresetn, por_n, rom_fetch, rom_protect_enable, debug_disable, m_rom, m_dbg;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int num_checks = 0;
  always #10 aclk = ~aclk;
  rdp_cpu_model cpu (.aclk, .rom_fetch, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rdp_top #(.FLASH_VARIANT(1'b1)) DUT (.aclk, .aresetn, .por_n, .rom_fetch, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rom_protect_enable, .debug_disable);
  rdp_top #(.FLASH_VARIANT(1'b0)) dut_mask (.aclk, .aresetn, .por_n, .rom_fetch,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready,
    .rom_protect_enable(m_rom), .debug_disable(m_dbg));
  // ----------
  // compares and accesses
  // ----------
  task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    chk_d({30'h0, got}, {30'h0, exp});
  endtask
  task automatic chk_b(input logic [3:0] got, input logic [3:0] exp);
    chk_d({28'h0, got}, {28'h0, exp});
  endtask
  task automatic pb(input logic [3:0] e);
    repeat (2) @(posedge aclk);
    chk_b({rom_protect_enable, debug_disable, m_rom, m_dbg}, e);
  endtask
  task automatic w(input logic [31:0] a, input logic [31:0] d, input logic f,
      input logic [1:0] er);
    cpu.wr(a, d, rdp_pkg::STRB_FULL, f, resp);
    chk_r(resp, er);
  endtask
  task automatic r(input logic [31:0] a, input logic f, input logic [1:0] er,
      input logic [31:0] ed);
    cpu.rd(a, f, rdat, resp);
    chk_r(resp, er);
    chk_d(rdat, ed);
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    print_verdict();
  end
  // ----------
  // tests
  // ----------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    por_n = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    pb(4'hf);
    r(AD_DM, 1'b1, OK, 32'h1);
    r(AD_RM, 1'b1, OK, 32'h1);
    r(AD_RL, 1'b1, OK, rdp_pkg::LOCK_READ_VALUE);
    cpu.slow = 1'b1;
    r(AD_RM, 1'b0, SE, 32'h0);
    w(AD_RM, 32'h0, 1'b0, SE);
    cpu.slow = 1'b0;
    w(AD_RL, rdp_pkg::ROM_KEY, 1'b0, SE);
    pb(4'hf);
    w(AD_RM, 32'h0, 1'b1, OK);
    w(AD_RL, 32'h0000003c, 1'b1, OK);
    pb(4'hf);
    w(AD_RL, rdp_pkg::ROM_KEY, 1'b1, OK);
    pb(4'h5);
    r(AD_RM, 1'b0, OK, 32'h0);
    w(AD_DM, 32'h0, 1'b0, OK);
    w(AD_DL, 32'h000000c4, 1'b0, OK);
    pb(4'h5);
    w(AD_DL, rdp_pkg::DEBUG_KEY, 1'b0, OK);
    pb(4'h0);
    w(AD_DM, 32'hffffffff, 1'b0, OK);
    r(AD_DM, 1'b0, OK, 32'h0);
    r(AD_DL, 1'b0, OK, rdp_pkg::LOCK_READ_VALUE);
    cpu.wr(AD_DL, rdp_pkg::DEBUG_KEY, 4'h1, 1'b0, resp);
    chk_r(resp, SE);
    pb(4'h0);
    cpu.slow = 1'b1;
    w(32'hffffe520, 32'h0, 1'b0, DE);
    r(32'hffffe520, 1'b0, DE, 32'h0);
    cpu.slow = 1'b0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pb(4'h3);
    w(AD_DL, rdp_pkg::DEBUG_KEY, 1'b0, OK);
    pb(4'h7);
    @(posedge aclk);
    por_n <= 1'b0;
    repeat (3) @(posedge aclk);
    por_n <= 1'b1;
    pb(4'hf);
    print_verdict();
  end
endmodule
`default_nettype wire
